//--- core/lbs_top.sv
// Local bus status, strap and pin logic with Wishbone register slave
`timescale 1ns/10ps
module lbs_top
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic sync_ready_in,
  input wire logic async_ready_in,
  input wire logic test_strap_in,
  input wire logic timer_input_zero,
  input wire logic timer_input_one,
  output logic timer_output_zero,
  output logic timer_output_one,
  input wire logic [19:0] mem_addr,
  input wire logic upper_memory_select_in,
  input wire logic lower_memory_select_in,
  output logic upper_memory_select,
  output logic upper_memory_select_oe_n,
  input wire logic read_strobe_queue_strap_in,
  output lbs_pkg::lbs_bus_pins_s bus_pins,
  output logic bus_hold_grant,
  output logic system_clock_out,
  output logic enhanced_mode,
  output logic float_all,
  output logic int_service
);
  logic rst_d_ff;
  logic clk_div_ff;
  logic clk_en;
  logic [3:0] strap_cnt_ff;
  logic strap_hi_ff;
  logic enhanced_ff;
  logic float_ff;
  logic qs_mode_ff;
  logic strap_done_ff;
  logic [31:0] ctrl_ff;
  logic [31:0] upper_ff;
  logic [31:0] timer_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic async_rdy_s;
  logic tin0_s;
  logic tin1_s;
  logic tin0_d_ff;
  logic tin1_d_ff;
  logic waiting_ff;
  logic [2:0] poll_ff;
  logic cyc_active_ff;
  logic [2:0] code_ff;
  logic wr_n_ff;
  logic ale_ff;
  logic rd_n_ff;
  logic [1:0] qs_ff;
  logic [15:0] tcnt0_ff;
  logic [15:0] tcnt1_ff;
  logic tout0_ff;
  logic tout1_ff;
  logic upper_sel_n_ff;
  logic ready;
  logic hold;
  logic wb_req;
  logic [15:0] tdiv;
  logic [19:0] upper_base;
  ////////////////////////////////////////////////////////////////////////////
  // Clock output and strap capture
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      clk_div_ff <= 1'b0;
    else
      clk_div_ff <= ~clk_div_ff;
  end
  assign clk_en = clk_div_ff;
  assign system_clock_out = clk_div_ff;
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      rst_d_ff <= 1'b1;
    else
      rst_d_ff <= 1'b0;
  end
  // Straps caught on the first clock after release, never under reset
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      strap_cnt_ff <= 4'h0;
      strap_hi_ff <= 1'b0;
      enhanced_ff <= 1'b0;
      float_ff <= 1'b0;
      qs_mode_ff <= 1'b0;
      strap_done_ff <= 1'b0;
    end
    else if (rst_d_ff)
    begin
      strap_hi_ff <= test_strap_in;
      float_ff <= ~upper_memory_select_in & ~lower_memory_select_in;
      qs_mode_ff <= ~read_strobe_queue_strap_in;
      strap_cnt_ff <= 4'h0;
    end
    else if (!strap_done_ff)
    begin
      if (strap_cnt_ff == lbs_pkg::MODE_SAMPLE_LAST)
      begin
        enhanced_ff <= strap_hi_ff & ~test_strap_in;
        strap_done_ff <= 1'b1;
      end
      else
        strap_cnt_ff <= strap_cnt_ff + 4'h1;
    end
  end
  assign enhanced_mode = enhanced_ff;
  assign float_all = float_ff;
  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      ack_ff <= 1'b0;
    else
      ack_ff <= wb_req;
  end
  assign wb_ack_o = ack_ff;
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ctrl_ff <= lbs_pkg::CTRL_RST;
      upper_ff <= lbs_pkg::UPPER_RST;
      timer_ff <= lbs_pkg::TIMER_RST;
    end
    else if (wb_req && wb_we_i)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (wb_sel_i[b])
        begin
          unique case (wb_adr_i)
            lbs_pkg::REG_CTRL: ctrl_ff[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            lbs_pkg::REG_UPPER: upper_ff[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            lbs_pkg::REG_TIMER: timer_ff[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            default: ;
          endcase
        end
      end
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      rdata_ff <= 32'h0;
    else if (wb_req)
    begin
      unique case (wb_adr_i)
        lbs_pkg::REG_CTRL: rdata_ff <= ctrl_ff;
        lbs_pkg::REG_UPPER: rdata_ff <= upper_ff;
        lbs_pkg::REG_TIMER: rdata_ff <= timer_ff;
        lbs_pkg::REG_STATUS: rdata_ff <= {16'h0, qs_ff, tout1_ff, tout0_ff, tin1_s, tin0_s, upper_sel_n_ff,
          cyc_active_ff, ready, waiting_ff, float_ff, qs_mode_ff, enhanced_ff, code_ff};
        default: rdata_ff <= 32'h0;
      endcase
    end
  end
  assign wb_dat_o = rdata_ff;
  ////////////////////////////////////////////////////////////////////////////
  // Ready and wait
  lbs_sync u_async_rdy (.sys_clk(sys_clk), .srst(srst), .d(async_ready_in), .q(async_rdy_s));
  assign ready = sync_ready_in | async_rdy_s;
  assign hold = ctrl_ff[lbs_pkg::CTRL_HOLD_BIT];
  assign bus_hold_grant = hold & ~float_ff;
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      waiting_ff <= 1'b0;
      poll_ff <= 3'h0;
    end
    else if (!waiting_ff)
    begin
      waiting_ff <= ctrl_ff[lbs_pkg::CTRL_WAIT_BIT] & test_strap_in & strap_done_ff;
      poll_ff <= 3'h0;
    end
    else if (poll_ff == lbs_pkg::WAIT_POLL_LAST)
    begin
      poll_ff <= 3'h0;
      waiting_ff <= test_strap_in;
    end
    else
      poll_ff <= poll_ff + 3'h1;
  end
  // Interrupts still taken while suspended
  assign int_service = waiting_ff & ctrl_ff[lbs_pkg::CTRL_IE_BIT];
  ////////////////////////////////////////////////////////////////////////////
  // Bus cycle sequencing
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      cyc_active_ff <= 1'b0;
      code_ff <= lbs_pkg::CYC_PASSIVE;
      wr_n_ff <= 1'b1;
      ale_ff <= 1'b0;
      rd_n_ff <= 1'b1;
    end
    else if (clk_en)
    begin
      ale_ff <= 1'b0;
      if (!cyc_active_ff && ctrl_ff[lbs_pkg::CTRL_REQ_BIT] && !hold && !waiting_ff)
      begin
        cyc_active_ff <= 1'b1;
        ale_ff <= 1'b1;
        code_ff <= {ctrl_ff[lbs_pkg::CTRL_MEM_BIT], ctrl_ff[lbs_pkg::CTRL_DIR_BIT],
          ~ctrl_ff[lbs_pkg::CTRL_DIR_BIT] & ~ctrl_ff[lbs_pkg::CTRL_FETCH_BIT]};
        wr_n_ff <= ~ctrl_ff[lbs_pkg::CTRL_DIR_BIT];
        rd_n_ff <= ctrl_ff[lbs_pkg::CTRL_DIR_BIT];
      end
      else if (cyc_active_ff && ready)
      begin
        cyc_active_ff <= 1'b0;
        code_ff <= lbs_pkg::CYC_PASSIVE;
        wr_n_ff <= 1'b1;
        rd_n_ff <= 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      qs_ff <= lbs_pkg::QS_NONE;
    else
      qs_ff <= ctrl_ff[lbs_pkg::CTRL_QS_LO +: 2];
  end
  always_comb
  begin
    bus_pins.code = code_ff;
    bus_pins.code_oe_n = {3{hold | float_ff}};
    bus_pins.rd_out = rd_n_ff;
    bus_pins.rd_oe_n = hold | float_ff;
    if (qs_mode_ff)
    begin
      bus_pins.wr_out = qs_ff[1];
      bus_pins.ale_out = qs_ff[0];
      bus_pins.wr_oe_n = hold | float_ff | srst;
      bus_pins.ale_oe_n = float_ff;
    end
    else
    begin
      bus_pins.wr_out = wr_n_ff;
      bus_pins.ale_out = ale_ff;
      bus_pins.wr_oe_n = hold | float_ff | srst;
      bus_pins.ale_oe_n = hold | float_ff;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Upper select, compared on the full 20-bit address
  assign upper_base = upper_ff[19:0];
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      upper_sel_n_ff <= 1'b1;
    else
      upper_sel_n_ff <= ~(cyc_active_ff & code_ff[2] & (mem_addr >= upper_base));
  end
  assign upper_memory_select = upper_sel_n_ff;
  assign upper_memory_select_oe_n = float_ff;
  ////////////////////////////////////////////////////////////////////////////
  // Timers
  lbs_sync u_tin0 (.sys_clk(sys_clk), .srst(srst), .d(timer_input_zero), .q(tin0_s));
  lbs_sync u_tin1 (.sys_clk(sys_clk), .srst(srst), .d(timer_input_one), .q(tin1_s));
  assign tdiv = timer_ff[lbs_pkg::TMR_DIV_LO +: 16];
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      tin0_d_ff <= 1'b0;
      tin1_d_ff <= 1'b0;
    end
    else
    begin
      tin0_d_ff <= tin0_s;
      tin1_d_ff <= tin1_s;
    end
  end
  // Edge mode counts rising edges; level mode counts clock-out ticks while high
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      tcnt0_ff <= 16'h0;
      tout0_ff <= 1'b0;
    end
    else if (timer_ff[lbs_pkg::TMR_EDGE0_BIT] ? (tin0_s & ~tin0_d_ff) : (tin0_s & clk_en))
    begin
      if (tcnt0_ff >= tdiv)
      begin
        tcnt0_ff <= 16'h0;
        tout0_ff <= timer_ff[lbs_pkg::TMR_CONT0_BIT] ? ~tout0_ff : 1'b1;
      end
      else
      begin
        tcnt0_ff <= tcnt0_ff + 16'h1;
        if (!timer_ff[lbs_pkg::TMR_CONT0_BIT])
          tout0_ff <= 1'b0;
      end
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      tcnt1_ff <= 16'h0;
      tout1_ff <= 1'b0;
    end
    else if (timer_ff[lbs_pkg::TMR_EDGE1_BIT] ? (tin1_s & ~tin1_d_ff) : (tin1_s & clk_en))
    begin
      if (tcnt1_ff >= tdiv)
      begin
        tcnt1_ff <= 16'h0;
        tout1_ff <= timer_ff[lbs_pkg::TMR_CONT1_BIT] ? ~tout1_ff : 1'b1;
      end
      else
      begin
        tcnt1_ff <= tcnt1_ff + 16'h1;
        if (!timer_ff[lbs_pkg::TMR_CONT1_BIT])
          tout1_ff <= 1'b0;
      end
    end
  end
  // Driven regardless of hold
  assign timer_output_zero = tout0_ff;
  assign timer_output_one = tout1_ff;
endmodule // lbs_top

//--- core/lbs_pkg.sv
// Package: constants and carriers for the local bus status and strap block
package lbs_pkg;
  localparam logic [2:0] CYC_INTA = 3'h0;
  localparam logic [2:0] CYC_IO_RD = 3'h1;
  localparam logic [2:0] CYC_IO_WR = 3'h2;
  localparam logic [2:0] CYC_HALT = 3'h3;
  localparam logic [2:0] CYC_FETCH = 3'h4;
  localparam logic [2:0] CYC_MEM_RD = 3'h5;
  localparam logic [2:0] CYC_MEM_WR = 3'h6;
  localparam logic [2:0] CYC_PASSIVE = 3'h7;
  localparam logic [1:0] QS_NONE = 2'h0;
  localparam logic [1:0] QS_FIRST = 2'h1;
  localparam logic [1:0] QS_EMPTY = 2'h2;
  localparam logic [1:0] QS_NEXT = 2'h3;
  localparam int MODE_SAMPLE_SYSTEM_CLOCK_OUT = 4;
  localparam int WAIT_POLL_CLKS = 5;
  localparam logic [3:0] MODE_SAMPLE_LAST = 4'(2 * MODE_SAMPLE_SYSTEM_CLOCK_OUT - 1);
  localparam logic [2:0] WAIT_POLL_LAST = 3'(WAIT_POLL_CLKS - 1);
  // Register offsets (word aligned)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_UPPER = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_TIMER = 4'hc;
  localparam logic [31:0] CTRL_RST = 32'h0;
  localparam logic [31:0] UPPER_RST = 32'h0;
  localparam logic [31:0] TIMER_RST = 32'h0;
  localparam int CTRL_WAIT_BIT = 0;
  localparam int CTRL_IE_BIT = 1;
  localparam int CTRL_HOLD_BIT = 2;
  localparam int CTRL_REQ_BIT = 3;
  localparam int CTRL_DIR_BIT = 4;
  localparam int CTRL_MEM_BIT = 5;
  localparam int CTRL_FETCH_BIT = 6;
  localparam int CTRL_QS_LO = 8;
  localparam int TMR_EDGE0_BIT = 0;
  localparam int TMR_EDGE1_BIT = 1;
  localparam int TMR_CONT0_BIT = 2;
  localparam int TMR_CONT1_BIT = 3;
  localparam int TMR_DIV_LO = 8;
  typedef struct packed {
    logic [2:0] code;
    logic [2:0] code_oe_n;
    logic wr_out;
    logic wr_oe_n;
    logic ale_out;
    logic ale_oe_n;
    logic rd_out;
    logic rd_oe_n;
  } lbs_bus_pins_s;
endpackage

//--- core/lbs_sync.sv
// Two-flop synchroniser for level inputs
`timescale 1ns/10ps
module lbs_sync
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic d,
  output logic q
);
  logic meta_ff;
  logic q_ff;
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      meta_ff <= 1'b0;
      q_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
  assign q = q_ff;
endmodule // lbs_sync

//--- test/lbs_props.sv
// Concurrent checks on the local bus status block ports
`timescale 1ns/10ps
module lbs_props
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic wb_ack_o,
  input wire lbs_pkg::lbs_bus_pins_s bus_pins,
  input wire logic bus_hold_grant,
  input wire logic float_all,
  input wire logic upper_memory_select_oe_n,
  input wire logic system_clock_out,
  input wire logic enhanced_mode,
  input wire logic int_service
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////
  // Skip first edge after release, clock out still holds its reset value
  a_clk_half: assert property (!$past(srst) |-> system_clock_out != $past(system_clock_out))
    else $error("clock out did not toggle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_hold_code: assert property (bus_hold_grant |-> bus_pins.code_oe_n == 3'h7)
    else $error("cycle code driven during hold");
  a_hold_strobe: assert property (bus_hold_grant |-> bus_pins.wr_oe_n && bus_pins.rd_oe_n)
    else $error("strobes driven during hold");
  a_hold_ucs: assert property (bus_hold_grant |-> !upper_memory_select_oe_n)
    else $error("upper select floated during hold");
  a_float_pins: assert property (float_all |-> bus_pins.code_oe_n == 3'h7 && bus_pins.wr_oe_n && bus_pins.ale_oe_n
    && bus_pins.rd_oe_n && upper_memory_select_oe_n)
    else $error("pin driven in float mode");
  a_float_keep: assert property (float_all |=> float_all)
    else $error("float mode left without reset");
  a_reset_idle: assert property ($fell(srst) |-> bus_pins.code == 3'h7 && bus_pins.wr_out)
    else $error("bus not idle after reset");
  a_reset_strobe: assert property (disable iff (1'b0) srst |-> bus_pins.wr_oe_n)
    else $error("write strobe driven in reset");
  c_float: cover property (float_all);
  c_hold: cover property (bus_hold_grant);
  c_int: cover property (int_service);
  c_enh: cover property (enhanced_mode);
endmodule // lbs_props

//--- test/lbs_far_model.sv
// Far side model: memory or peripheral answering with ready
`timescale 1ns/10ps
module lbs_far_model
(
  input wire logic sys_clk,
  input wire logic [2:0] code,
  input wire logic hold,
  input wire logic [1:0] mode,
  output logic sync_ready_out,
  output logic async_ready_out
);
  logic busy;
  // Mode 0 stalls forever so the bench can inspect a waiting cycle
  assign busy = (code != 3'h7) && !hold;
  // Top code bit selects memory, middle bit direction; one answer serves both
  always_ff @(posedge sys_clk)
  begin
    sync_ready_out <= busy && (mode == 2'h1);
    async_ready_out <= busy && (mode == 2'h2);
  end
endmodule // lbs_far_model

//--- test/lbs_top_tb.sv
// Self-checking bench for the local bus status block
`timescale 1ns/10ps
module lbs_top_tb;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] q;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic [31:0] rdat;
  logic ack;
  logic sync_rdy, async_rdy, tst = 1'b0, tin0 = 1'b0, tin1 = 1'b0, upper_strap = 1'b1, lower_strap = 1'b1;
  logic rd_s = 1'b1;
  logic [19:0] maddr = 20'h0;
  logic [1:0] mode = 2'h0;
  lbs_pkg::lbs_bus_pins_s pins;
  logic hold_grant, upper_sel, upper_sel_oe_n, enh, flt, isv;
  logic tout0, tout1;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [6:0] ctl [5] = '{7'h08, 7'h18, 7'h68, 7'h28, 7'h38};
  logic [2:0] cod [5] = '{lbs_pkg::CYC_IO_RD, lbs_pkg::CYC_IO_WR, lbs_pkg::CYC_FETCH, lbs_pkg::CYC_MEM_RD,
    lbs_pkg::CYC_MEM_WR};
  initial forever #2.5 sys_clk = ~sys_clk;
  lbs_top dut_u (.sys_clk(sys_clk), .srst(srst), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we),
    .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .sync_ready_in(sync_rdy),
    .async_ready_in(async_rdy), .test_strap_in(tst), .timer_input_zero(tin0), .timer_input_one(tin1),
    .timer_output_zero(tout0), .timer_output_one(tout1), .mem_addr(maddr),
    .upper_memory_select_in(upper_strap), .lower_memory_select_in(lower_strap),
    .upper_memory_select(upper_sel), .upper_memory_select_oe_n(upper_sel_oe_n), .read_strobe_queue_strap_in(rd_s),
    .bus_pins(pins), .bus_hold_grant(hold_grant), .system_clock_out(), .enhanced_mode(enh), .float_all(flt),
    .int_service(isv));
  lbs_far_model far_u (.sys_clk(sys_clk), .code(pins.code), .hold(hold_grant), .mode(mode),
    .sync_ready_out(sync_rdy), .async_ready_out(async_rdy));
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Classic single cycle; ack and data are taken at the same edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (n >= 50)
      chk(32'h1, 32'h0);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Straps are upper, lower, read; test strap at release then four clock-out cycles on
  task automatic rst(input logic u, input logic l, input logic r, input logic t0, input logic t1);
    @(posedge sys_clk);
    srst <= 1'b1;
    upper_strap <= u;
    lower_strap <= l;
    rd_s <= r;
    tst <= t0;
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    tst <= t1;
    repeat (8) @(posedge sys_clk);
    upper_strap <= 1'b1;
    lower_strap <= 1'b1;
    rd_s <= 1'b1;
    tst <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      summarize();
    end
  end
  initial
  begin
    int n;
    rst(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    chk(enh, 1'b1);
    wb(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, lbs_pkg::REG_CTRL, 32'h0);
    chk(q, lbs_pkg::CTRL_RST);
    wb(1'b0, lbs_pkg::REG_TIMER, 32'h0);
    chk(q, lbs_pkg::TIMER_RST);
    wb(1'b1, lbs_pkg::REG_UPPER, 32'h80000);
    wb(1'b0, lbs_pkg::REG_UPPER, 32'h0);
    chk(q, 32'h80000);
    for (int i = 0; i < 5; i++)
    begin
      maddr <= i[0] ? 20'h90000 : 20'h10000;
      wb(1'b1, lbs_pkg::REG_CTRL, {25'h0, ctl[i]});
      repeat (8) @(posedge sys_clk);
      chk(pins.code, cod[i]);
      chk(pins.wr_out, !ctl[i][4]);
      chk(pins.rd_out, ctl[i][4]);
      chk(upper_sel, !(ctl[i][5] && i[0]));
      wb(1'b1, lbs_pkg::REG_CTRL, 32'h0);
      chk(pins.code, cod[i]);
      mode <= i[0] ? 2'h2 : 2'h1;
      n = 0;
      while (pins.code !== 3'h7 && n < 40)
      begin
        @(posedge sys_clk);
        n++;
      end
      chk(pins.code, lbs_pkg::CYC_PASSIVE);
      mode <= 2'h0;
    end
    wb(1'b1, lbs_pkg::REG_CTRL, 32'h4);
    repeat (2) @(posedge sys_clk);
    chk(hold_grant, 1'b1);
    chk(pins.code_oe_n, 3'h7);
    wb(1'b1, lbs_pkg::REG_CTRL, 32'h0);
    tst <= 1'b1;
    wb(1'b1, lbs_pkg::REG_CTRL, 32'h3);
    repeat (4) @(posedge sys_clk);
    chk(isv, 1'b1);
    wb(1'b0, lbs_pkg::REG_STATUS, 32'h0);
    chk(q[6], 1'b1);
    wb(1'b1, lbs_pkg::REG_CTRL, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk(isv, 1'b0);
    tst <= 1'b0;
    repeat (12) @(posedge sys_clk);
    wb(1'b0, lbs_pkg::REG_STATUS, 32'h0);
    chk(q[6], 1'b0);
    wb(1'b1, lbs_pkg::REG_CTRL, 32'h0);
    for (int i = 1; i < 3; i++)
    begin
      tin0 <= i[0];
      tin1 <= i[1];
      repeat (4) @(posedge sys_clk);
      wb(1'b0, lbs_pkg::REG_STATUS, 32'h0);
      chk(q[11:10], i[1:0]);
    end
    // Both timers reached terminal count zero in level mode; outputs stay up under hold
    wb(1'b1, lbs_pkg::REG_CTRL, 32'h4);
    chk(tout0, 1'b1);
    chk(tout1, 1'b1);
    wb(1'b1, lbs_pkg::REG_TIMER, 32'h101);
    tin0 <= 1'b1;
    repeat (5) @(posedge sys_clk);
    tin0 <= 1'b0;
    repeat (5) @(posedge sys_clk);
    chk(tout0, 1'b0);
    tin0 <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk(tout0, 1'b1);
    wb(1'b1, lbs_pkg::REG_CTRL, 32'h0);
    rst(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    chk(enh, 1'b0);
    wb(1'b0, lbs_pkg::REG_STATUS, 32'h0);
    chk(q[4], 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, lbs_pkg::REG_CTRL, i << 8);
      repeat (2) @(posedge sys_clk);
      chk({pins.wr_out, pins.ale_out}, i[1:0]);
    end
    rst(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    chk(flt, 1'b1);
    chk(upper_sel_oe_n, 1'b1);
    rst(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    chk(flt, 1'b0);
    chk(enh, 1'b0);
    summarize();
  end
endmodule // lbs_top_tb
bind lbs_top lbs_props props_u (.sys_clk(sys_clk), .srst(srst), .wb_ack_o(wb_ack_o), .bus_pins(bus_pins),
  .bus_hold_grant(bus_hold_grant), .float_all(float_all), .upper_memory_select_oe_n(upper_memory_select_oe_n),
  .system_clock_out(system_clock_out), .enhanced_mode(enhanced_mode), .int_service(int_service));
